// ===== rtl/pcm_pin_mux.sv
// port c pin multiplexer with axi4-lite register slave
// assumes peripheral controls arrive on aclk, pins arrive asynchronously
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module pcm_pin_mux
    import pcm_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // port pins
    input  wire logic [7:0]        pin_in,
    output logic [7:0]             pin_out,
    output logic [7:0]             pin_oe,
    output logic [4:3]             pin_smbus_buf,
    // alternate port bit three for channel two
    input  wire logic              alt_port_bit_three_in,
    output logic                   alt_port_bit_three_out,
    output logic                   alt_port_bit_three_oe,
    // sync_serial_module, spi side
    input  wire logic              spi_enable,
    input  wire logic              spi_master,
    input  wire logic              spi_clock_out,
    input  wire logic              spi_serial_out,
    output logic                   spi_clock_in,
    output logic                   spi_serial_in,
    // sync_serial_module, i2c side
    input  wire logic              i2c_enable,
    input  wire logic              i2c_smbus_levels,
    input  wire logic              i2c_clock_pull_low,
    input  wire logic              i2c_data_pull_low,
    output logic                   i2c_clock_in,
    output logic                   i2c_data_in,
    // usart_module
    input  wire logic              usart_enable,
    input  wire logic              usart_sync_mode,
    input  wire logic              usart_sync_master,
    input  wire logic              usart_sync_transmit,
    input  wire logic              usart_tx_data,
    input  wire logic              usart_sync_clock_out,
    output logic                   usart_rx_in,
    output logic                   usart_sync_clock,
    output logic                   usart_sync_data,
    // capture_compare_channel_two
    input  wire logic              capture_two_pin_select,
    input  wire logic              capture_two_out,
    input  wire logic              capture_two_drive,
    output logic                   capture_two_in
);

    // software-visible state
    logic [7:0]        port_output_latch;  // output latch
    logic [7:0]        port_direction;     // 1 = input
    logic [7:0]        pin_sync;           // synchronised pin levels
    logic              alt_sync;           // synchronised alternate pin

    // write path holding
    pcm_wr_t           wr_state;
    logic              aw_held;            // address captured
    logic              w_held;             // data captured
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic              wr_lane;            // low byte lane enabled
    pcm_rd_t           rd_state;

    // combinational pin drive
    logic [7:0]        next_pin_out;
    logic [7:0]        next_pin_oe;
    logic [7:0]        plain_out;          // latch-driven default
    logic [7:0]        plain_oe;
    logic              next_alt_out;
    logic              next_alt_oe;

    // register decode, used by both read and write paths
    function automatic pcm_reg_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            OFS_PIN:   decode = PCM_REG_PIN;
            OFS_LATCH: decode = PCM_REG_LATCH;
            OFS_DIR:   decode = PCM_REG_DIR;
            OFS_DRIVE: decode = PCM_REG_DRIVE;
            default:   decode = PCM_REG_NONE;
        endcase
    endfunction : decode

    // pins and the alternate pin are asynchronous; two flops first
    pcm_sync #(
        .W (9)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({alt_port_bit_three_in, pin_in}),
        .sync_out ({alt_sync, pin_sync})
    );

    // default port behaviour per pin: latch out when direction is 0
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_plain
            assign plain_out[gi] = port_output_latch[gi];
            assign plain_oe[gi]  = ~port_direction[gi];
        end
    endgenerate

    // peripheral overrides on top of the plain port
    always_comb begin
        next_pin_out = plain_out;
        next_pin_oe  = plain_oe;
        next_alt_out = 1'b0;
        next_alt_oe  = 1'b0;

        // bit one: channel two when mapped to its default pin
        if (capture_two_pin_select) begin
            if (capture_two_drive && !port_direction[BIT_CAP2]) begin
                next_pin_out[BIT_CAP2] = capture_two_out;
                next_pin_oe[BIT_CAP2]  = 1'b1;
            end
        end else begin
            // cleared select moves the channel to the other port
            next_alt_out = capture_two_out;
            next_alt_oe  = capture_two_drive;
        end

        // bit three: i2c clock wins, else spi master clock
        if (i2c_enable) begin
            // open drain: only ever pull low, direction ignored
            next_pin_out[BIT_CLK] = 1'b0;
            next_pin_oe[BIT_CLK]  = i2c_clock_pull_low;
        end else if (spi_enable && spi_master && !port_direction[BIT_CLK]) begin
            next_pin_out[BIT_CLK] = spi_clock_out;
            next_pin_oe[BIT_CLK]  = 1'b1;
        end

        // bit four: i2c data drives even with direction left at 1
        if (i2c_enable) begin
            next_pin_out[BIT_DAT] = 1'b0;
            next_pin_oe[BIT_DAT]  = i2c_data_pull_low;
        end

        // bit five: spi serial out when direction is 0
        if (spi_enable && !port_direction[BIT_SPI_OUT]) begin
            next_pin_out[BIT_SPI_OUT] = spi_serial_out;
            next_pin_oe[BIT_SPI_OUT]  = 1'b1;
        end

        // bit six: transmit, sync master clock or sync slave input
        if (usart_enable && !usart_sync_mode) begin
            // software should also clear the direction bit here
            next_pin_out[BIT_TX] = usart_tx_data;
            next_pin_oe[BIT_TX]  = 1'b1;
        end else if (usart_enable && usart_sync_master) begin
            next_pin_out[BIT_TX] = usart_sync_clock_out;
            next_pin_oe[BIT_TX]  = 1'b1;
        end else if (usart_enable) begin
            next_pin_oe[BIT_TX]  = 1'b0;
        end

        // bit seven: sync transmit drives, sync receive releases
        if (usart_enable && usart_sync_mode) begin
            if (usart_sync_transmit) begin
                next_pin_out[BIT_RX] = usart_tx_data;
                next_pin_oe[BIT_RX]  = 1'b1;
            end else begin
                next_pin_oe[BIT_RX]  = 1'b0;
            end
        end
    end

    // pin drivers registered; reset leaves every pin an input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out                <= RST_PINS;
            pin_oe                 <= RST_PINS;
            alt_port_bit_three_out <= 1'b0;
            alt_port_bit_three_oe  <= 1'b0;
        end else begin
            pin_out                <= next_pin_out;
            pin_oe                 <= next_pin_oe;
            alt_port_bit_three_out <= next_alt_out;
            alt_port_bit_three_oe  <= next_alt_oe;
        end
    end

    // input buffer select for the i2c pins follows the module setting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_smbus_buf <= 2'h0;
        end else begin
            pin_smbus_buf <= {2{i2c_enable & i2c_smbus_levels}};
        end
    end

    // serial and spi inputs from synchronised pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_clock_in  <= 1'b0;
            spi_serial_in <= 1'b0;
            i2c_clock_in  <= 1'b1;
            i2c_data_in   <= 1'b1;
        end else begin
            // spi sees the pin only when it is an input
            spi_clock_in  <= port_direction[BIT_CLK] & pin_sync[BIT_CLK];
            spi_serial_in <= port_direction[BIT_DAT] & pin_sync[BIT_DAT];
            // i2c reads the bus line back, buffer chosen above
            i2c_clock_in  <= pin_sync[BIT_CLK];
            i2c_data_in   <= pin_sync[BIT_DAT];
        end
    end

    // usart and channel two inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usart_rx_in      <= 1'b1;
            usart_sync_clock <= 1'b0;
            usart_sync_data  <= 1'b0;
            capture_two_in   <= 1'b0;
        end else begin
            // idle-high receive line while the pin is not an input
            usart_rx_in      <= ~port_direction[BIT_RX] | pin_sync[BIT_RX];
            usart_sync_clock <= pin_sync[BIT_TX];
            usart_sync_data  <= pin_sync[BIT_RX];
            capture_two_in   <= capture_two_pin_select ? pin_sync[BIT_CAP2]
                                                       : alt_sync;
        end
    end

    // write address channel: one address held until the response ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            wr_addr       <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_state == PCM_WR_RESP && s_axi_bready) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel: taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            wr_byte      <= 8'h00;
            wr_lane      <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            wr_byte      <= s_axi_wdata[7:0];
            wr_lane      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_state == PCM_WR_RESP && s_axi_bready) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // response once both halves are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= PCM_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            case (wr_state)
                PCM_WR_IDLE: begin
                    if (aw_held && w_held) begin
                        wr_state     <= PCM_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (decode(wr_addr) == PCM_REG_NONE)
                                        ? RESP_SLVERR : RESP_OKAY;
                    end
                end
                PCM_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state     <= PCM_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state     <= PCM_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // register writes happen on the idle-to-response step
    // a write to the pin-state address lands in the latch, since pins
    // themselves cannot hold a value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_output_latch <= RST_LATCH;
            port_direction    <= RST_DIR;
        end else if (wr_state == PCM_WR_IDLE && aw_held && w_held && wr_lane) begin
            case (decode(wr_addr))
                PCM_REG_PIN:   port_output_latch <= wr_byte;
                PCM_REG_LATCH: port_output_latch <= wr_byte;
                PCM_REG_DIR:   port_direction    <= wr_byte;
                default:       port_output_latch <= port_output_latch;
            endcase
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state      <= PCM_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rd_state)
                PCM_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state      <= PCM_RD_DATA;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rresp   <= RESP_OKAY;
                        case (decode(s_axi_araddr))
                            // live pins, whatever drives them
                            PCM_REG_PIN:   s_axi_rdata <= {24'h0, pin_sync};
                            PCM_REG_LATCH: s_axi_rdata <= {24'h0, port_output_latch};
                            // stored value, even while a peripheral overrides
                            PCM_REG_DIR:   s_axi_rdata <= {24'h0, port_direction};
                            PCM_REG_DRIVE: s_axi_rdata <= {16'h0, pin_out, pin_oe};
                            default: begin
                                s_axi_rdata <= '0;
                                s_axi_rresp <= RESP_SLVERR;
                            end
                        endcase
                    end
                end
                PCM_RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state      <= PCM_RD_IDLE;
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid  <= 1'b0;
                    end
                end
                default: begin
                    rd_state      <= PCM_RD_IDLE;
                    s_axi_arready <= 1'b1;
                    s_axi_rvalid  <= 1'b0;
                end
            endcase
        end
    end

endmodule : pcm_pin_mux

// ===== rtl/pcm_pkg.sv
// constants, register map and state types for the port c pin multiplexer
// assumes a 32-bit axi4-lite register bus and a 50 MHz core clock
package pcm_pkg;

    // bus geometry
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 4;
    localparam int          PORT_W       = 8;

    // register byte offsets
    localparam logic [3:0]  OFS_PIN      = 4'h0;  // port_pin_state
    localparam logic [3:0]  OFS_LATCH    = 4'h4;  // port_output_latch
    localparam logic [3:0]  OFS_DIR      = 4'h8;  // port_direction
    localparam logic [3:0]  OFS_DRIVE    = 4'hC;  // live pin drive view

    // values after reset
    localparam logic [7:0]  RST_LATCH    = 8'h00;
    localparam logic [7:0]  RST_DIR      = 8'hFF;
    localparam logic [7:0]  RST_PINS     = 8'h00;

    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // pin positions
    localparam int          BIT_CAP2     = 1;
    localparam int          BIT_CLK      = 3;
    localparam int          BIT_DAT      = 4;
    localparam int          BIT_SPI_OUT  = 5;
    localparam int          BIT_TX       = 6;
    localparam int          BIT_RX       = 7;

    // register decode result
    typedef enum logic [4:0] {
        PCM_REG_PIN   = 5'h01,
        PCM_REG_LATCH = 5'h02,
        PCM_REG_DIR   = 5'h04,
        PCM_REG_DRIVE = 5'h08,
        PCM_REG_NONE  = 5'h10
    } pcm_reg_t;

    // write channel states
    typedef enum logic [1:0] {
        PCM_WR_IDLE = 2'h1,
        PCM_WR_RESP = 2'h2
    } pcm_wr_t;

    // read channel states
    typedef enum logic [1:0] {
        PCM_RD_IDLE = 2'h1,
        PCM_RD_DATA = 2'h2
    } pcm_rd_t;

endpackage : pcm_pkg

// ===== rtl/pcm_sync.sv
// two-stage synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level, no bus coherency needed
`timescale 1ns/10ps
module pcm_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;  // first stage, read only by the second

    // both stages clear on reset; the first is never tapped elsewhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : pcm_sync

// ===== verif/pcm_pin_mux_asserts.sv
// checker for the pin multiplexer: serial peripheral overrides and the bus data input path
// assumes one clock, synchronous active-low reset, controls stable between edges
`timescale 1ns/10ps
module pcm_pin_mux_asserts (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // pads
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // serial controls
    input wire logic       spi_enable,
    input wire logic       spi_master,
    input wire logic       spi_clock_out,
    input wire logic       spi_serial_out,
    input wire logic       i2c_enable,
    input wire logic       i2c_clock_pull_low,
    input wire logic       i2c_data_pull_low,
    input wire logic       i2c_data_in,
    input wire logic       usart_enable,
    input wire logic       usart_sync_mode,
    input wire logic       usart_sync_master,
    input wire logic       usart_sync_transmit,
    input wire logic       usart_tx_data,
    input wire logic       usart_sync_clock_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic live; // last edge was out of reset
    // track one edge of reset history
    always_ff @(posedge aclk) live <= aresetn;
    // pad low for three samples, the input path depth
    sequence s_low3(b); !b [*3]; endsequence
    property p_spi_clk; live && $past(spi_enable && spi_master && !i2c_enable)
        |-> !pin_oe[3] || pin_out[3] == $past(spi_clock_out); endproperty
    a_spi_clk: assert property (p_spi_clk) else $error("spi clock not on pin three");
    property p_i2c_clk; live && $past(i2c_enable)
        |-> pin_oe[3] == $past(i2c_clock_pull_low) && !(pin_oe[3] && pin_out[3]); endproperty
    a_i2c_clk: assert property (p_i2c_clk) else $error("bus clock drive wrong");
    property p_i2c_dat; live && $past(i2c_enable)
        |-> pin_oe[4] == $past(i2c_data_pull_low) && !(pin_oe[4] && pin_out[4]); endproperty
    a_i2c_dat: assert property (p_i2c_dat) else $error("bus data drive wrong");
    property p_dat_in; s_low3(pin_in[4]) |=> !i2c_data_in; endproperty
    a_dat_in: assert property (p_dat_in) else $error("bus data input stale");
    property p_spi_out; live && $past(spi_enable)
        |-> !pin_oe[5] || pin_out[5] == $past(spi_serial_out); endproperty
    a_spi_out: assert property (p_spi_out) else $error("spi data not on pin five");
    property p_tx; live && $past(usart_enable && !usart_sync_mode)
        |-> pin_oe[6] && pin_out[6] == $past(usart_tx_data); endproperty
    a_tx: assert property (p_tx) else $error("transmit not on pin six");
    property p_ck_mst; live && $past(usart_enable && usart_sync_mode && usart_sync_master)
        |-> pin_oe[6] && pin_out[6] == $past(usart_sync_clock_out); endproperty
    a_ck_mst: assert property (p_ck_mst) else $error("sync clock not driven");
    property p_ck_slv; live && $past(usart_enable && usart_sync_mode && !usart_sync_master)
        |-> !pin_oe[6]; endproperty
    a_ck_slv: assert property (p_ck_slv) else $error("slave clock pin driven");
    property p_dt_tx; live && $past(usart_enable && usart_sync_mode && usart_sync_transmit)
        |-> pin_oe[7] && pin_out[7] == $past(usart_tx_data); endproperty
    a_dt_tx: assert property (p_dt_tx) else $error("sync data not driven");
    property p_dt_rx; live && $past(usart_enable && usart_sync_mode && !usart_sync_transmit)
        |-> !pin_oe[7]; endproperty
    a_dt_rx: assert property (p_dt_rx) else $error("receive pin driven");
endmodule : pcm_pin_mux_asserts

bind pcm_pin_mux pcm_pin_mux_asserts u_pcm_pin_mux_asserts (.aclk, .aresetn, .pin_in,
    .pin_out, .pin_oe, .spi_enable, .spi_master, .spi_clock_out, .spi_serial_out, .i2c_enable,
    .i2c_clock_pull_low, .i2c_data_pull_low, .i2c_data_in, .usart_enable, .usart_sync_mode,
    .usart_sync_master, .usart_sync_transmit, .usart_tx_data, .usart_sync_clock_out);

// ===== verif/pcm_far_pins.sv
// far-side pad model: design drive, then external driver, then pulls
// assumes pads three and four carry bus pull-ups, other released pads float
`timescale 1ns/10ps
module pcm_far_pins (
    // clock
    input  wire logic       aclk,
    // design drive
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // external driver
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // resolved pads
    output logic      [7:0] pin_in
);
    localparam logic [7:0] PULL = 8'h18; // bus pull-ups
    logic [7:0] flt = 8'h55; // floating pads toggle
    // toggle floating levels every cycle
    always @(posedge aclk) flt <= ~flt;
    // design drive wins, then the external driver, then pull or float
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (PULL | flt));
endmodule : pcm_far_pins

// ===== verif/port_c_upper_pin_mux_test.sv
// self-checking bench for the pin multiplexer over axi4-lite
// assumes the far-side pad model and the bound checker
`timescale 1ns/10ps
module port_c_upper_pin_mux_test;
    import pcm_pkg::*;
    logic              aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'h0;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [7:0]        pin_in, pin_out, pin_oe, ext_en = 8'h00, ext_val = 8'h00;
    logic [4:3]        pin_smbus_buf;
    logic [17:0]       per = '0; // peripheral controls
    logic              spi_clock_in, spi_serial_in, i2c_clock_in, i2c_data_in, usart_rx_in;
    logic              alt_port_bit_three_out, alt_port_bit_three_oe, capture_two_in;
    logic              usart_sync_clock, usart_sync_data;
    logic [7:0]        lat, dir, pv;
    integer            bad_count = 0, checks = 0, seed = 58;

    pcm_pin_mux u_pcm_pin_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_smbus_buf,
        .alt_port_bit_three_in(per[17]), .alt_port_bit_three_out, .alt_port_bit_three_oe,
        .spi_enable(per[0]), .spi_master(per[1]), .spi_clock_out(per[2]),
        .spi_serial_out(per[3]), .spi_clock_in, .spi_serial_in, .i2c_enable(per[4]),
        .i2c_smbus_levels(per[5]), .i2c_clock_pull_low(per[6]), .i2c_data_pull_low(per[7]),
        .i2c_clock_in, .i2c_data_in, .usart_enable(per[8]), .usart_sync_mode(per[9]),
        .usart_sync_master(per[10]), .usart_sync_transmit(per[11]), .usart_tx_data(per[12]),
        .usart_sync_clock_out(per[13]), .usart_rx_in, .usart_sync_clock, .usart_sync_data,
        .capture_two_pin_select(per[14]), .capture_two_out(per[15]),
        .capture_two_drive(per[16]), .capture_two_in);
    pcm_far_pins u_pcm_far_pins (.aclk, .pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
    // free-running core clock
    always #10 aclk = ~aclk;

    // count and report one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one write; upper data bits are noise
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, (a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY);
    endtask : wr
    // one read, compared with its expected data and response
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
    endtask : rd_chk

    // pad levels: design drives outputs, the far side drives inputs
    function automatic logic [7:0] pins_exp(input logic [7:0] l, input logic [7:0] d,
                                            input logic [7:0] e);
        return (l & ~d) | (e & d);
    endfunction : pins_exp
    // single verdict point
    task automatic stop_test;
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(pin_oe, 8'h00);
        rd_chk(OFS_DIR, 32'h000000FF, RESP_OKAY);
        wr(4'h6, 8'hAA, 4'h1); // unmapped, no effect
        rd_chk(OFS_LATCH, 32'h0, RESP_OKAY);
        rd_chk(4'h2, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 16; i++) begin
            lat = 8'($random(seed));
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            ext_en <= dir;
            ext_val <= 8'($random(seed));
            per <= 18'($random(seed)) & 18'h24000;
            wr(i[0] ? OFS_PIN : OFS_LATCH, lat, 4'h1);
            wr(OFS_LATCH, ~lat, 4'h0); // strobe off: no write
            wr(OFS_DIR, dir, 4'h1);
            repeat (4) @(posedge aclk);
            pv = pins_exp(lat, dir, ext_val);
            chk(pin_oe, 8'(~dir));
            chk(pin_out & ~dir, lat & ~dir);
            rd_chk(OFS_LATCH, lat, RESP_OKAY);
            rd_chk(OFS_DIR, dir, RESP_OKAY);
            rd_chk(OFS_PIN, pv, RESP_OKAY);
            chk(spi_clock_in, dir[3] & ext_val[3]);
            chk(spi_serial_in, dir[4] & ext_val[4]);
            chk(usart_rx_in, !dir[7] || ext_val[7]);
            chk({usart_sync_data, usart_sync_clock}, pv[7:6]);
            chk(capture_two_in, per[14] ? pv[1] : per[17]);
        end
        // random peripheral traffic on output pads; checker judges
        ext_en <= 8'h00;
        wr(OFS_DIR, 8'h00, 4'h1);
        repeat (300) @(posedge aclk) per <= 18'($random(seed));
        // bus data pulled low despite input direction; channel two on alt pin
        per <= 18'h180B0;
        wr(OFS_DIR, 8'hFF, 4'h1);
        repeat (4) @(posedge aclk);
        chk(pin_oe, 8'h10);
        chk(pin_out[4], 1'b0);
        chk(i2c_data_in, 1'b0);
        chk(i2c_clock_in, 1'b1);
        chk({pin_smbus_buf, alt_port_bit_three_out, alt_port_bit_three_oe}, 4'hF);
        rd_chk(OFS_DRIVE, {16'h0, lat & 8'hE7, 8'h10}, RESP_OKAY);
        stop_test;
    end

    // hang guard, far past the run's length
    initial begin
        #400000;
        bad_count++;
        stop_test;
    end
endmodule : port_c_upper_pin_mux_test
